/* pkg/bst_pkg.sv */
// ****************************************
// test port constants
// ****************************************
package bst_pkg;
    localparam int IR_LEN = 10;
    localparam int ID_LEN = 32;
    localparam int USER_LEN = 32;
    localparam int SIG_LEN = 16;
    localparam int BSR_LEN_DEF = 96;
    // identification field positions
    localparam int ID_VER_POS = 28;
    localparam int ID_PART_POS = 12;
    localparam int ID_MAKER_POS = 1;
    // arbitrary neutral identity values
    localparam logic [3:0] ID_VER_DEF = 4'h1;
    localparam logic [15:0] ID_PART_DEF = 16'h1234;
    localparam logic [10:0] ID_MAKER_DEF = 11'h055;
    // default opcodes (configurable by parameter, except the programming range and IR_CAPTURE)
    localparam logic [9:0] OP_EXTEST = 10'h000;
    localparam logic [9:0] OP_SAMPLE = 10'h055;
    localparam logic [9:0] OP_IDCODE = 10'h059;
    localparam logic [9:0] OP_USERCODE = 10'h007;
    localparam logic [9:0] OP_SIGREAD = 10'h079;
    localparam logic [9:0] OP_ISP_FIRST = 10'h200;
    localparam logic [9:0] OP_ISP_LAST = 10'h2FF;
    localparam logic [9:0] OP_BYPASS = 10'h3FF;
    localparam logic [9:0] IR_CAPTURE = 10'h001;
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
        ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020, ST_PAUDR = 16'h0040, ST_EX2DR = 16'h0080,
        ST_UPDR = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000, ST_PAUIR = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR = 16'h8000
    } bst_state_t;
    typedef enum logic [6:0] {
        SEL_BYPASS = 7'h01, SEL_BSR = 7'h02, SEL_ID = 7'h04, SEL_USER = 7'h08,
        SEL_SIG = 7'h10, SEL_ISP = 7'h20, SEL_EXT = 7'h40
    } bst_sel_t;
endpackage : bst_pkg

/* pkg/bst_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// two-entry buffer link
// ****************************************
interface bst_buf_if #(parameter int W = 8);
    logic inValid;
    logic inReady;
    logic [W-1:0] inData;
    logic outValid;
    logic outReady;
    logic [W-1:0] outData;
    modport buffer (input inValid, output inReady, input inData,
                    output outValid, input outReady, output outData);
    modport user (output inValid, input inReady, output inData,
                  input outValid, output outReady, input outData);
endinterface : bst_buf_if
`default_nettype wire

/* hw/bst_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// two-entry buffer
// ****************************************
module bst_skid_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clkEn,
    bst_buf_if.buffer bus
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic push, pop;

    // honest full and empty from the fill count
    assign bus.inReady = (int'(count_r) < DEPTH);
    assign bus.outValid = (count_r != '0);
    assign bus.outData = mem[rdPtr_r];
    assign push = bus.inValid && bus.inReady && clkEn;
    assign pop = bus.outValid && bus.outReady && clkEn;

    // pointer and count updates
    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (push) begin
            wrPtr_nxt = (int'(wrPtr_r) == DEPTH - 1) ? '0 : wrPtr_r + 1'b1;
        end
        if (pop) begin
            rdPtr_nxt = (int'(rdPtr_r) == DEPTH - 1) ? '0 : rdPtr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // storage has no reset; guarded by the count
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_r] <= bus.inData;
        end
    end
endmodule : bst_skid_buf
`default_nettype wire

/* hw/bst_test_port.sv */
// Functional notes
// RULE_01: ten-bit instruction register, shifted from data input
// RULE_02: one-bit bypass stage between data pins
// RULE_03: sample captures pins, preload keeps shifted pattern
// RULE_04: external test drives outputs, captures inputs
// RULE_05: identification word shifts out, 32 bits
// RULE_06: version, part, maker, one-bit field layout
// RULE_07: identification lowest bit always one
// RULE_08: optional 32-bit user code readout
// RULE_09: optional 16-bit signature register readout
// RULE_10: boundary register length is a parameter
// RULE_11: programming instructions accepted and flagged
// RULE_12: unused port releases pins to user
// RULE_13: mode sampled on rise, output on fall
// RULE_14: opcodes configurable, unknown selects bypass; the programming range OP_ISP_FIRST to OP_ISP_LAST is fixed here
`timescale 1ns/1ps
`default_nettype none
module bst_test_port import bst_pkg::*; #(
    parameter int BSR_LEN = BSR_LEN_DEF,
    parameter bit HAS_USER = 1'b1,
    parameter bit HAS_SIG = 1'b1,
    parameter logic [9:0] OP_EXT = OP_EXTEST,
    parameter logic [9:0] OP_SMP = OP_SAMPLE,
    parameter logic [9:0] OP_ID = OP_IDCODE,
    parameter logic [9:0] OP_USR = OP_USERCODE,
    parameter logic [9:0] OP_SIG = OP_SIGREAD,
    parameter logic [9:0] OP_BYP = OP_BYPASS,
    parameter logic [3:0] ID_VER = ID_VER_DEF,
    parameter logic [15:0] ID_PART = ID_PART_DEF,
    parameter logic [10:0] ID_MAKER = ID_MAKER_DEF
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic portEnable,
    input wire logic tckPin,
    input wire logic tmsPin,
    input wire logic tdiPin,
    output logic tdoOut,
    output logic tdoOe,
    input wire logic [31:0] userCode,
    input wire logic [15:0] signature,
    input wire logic [BSR_LEN-1:0] pinIn,
    input wire logic [BSR_LEN-1:0] coreOut,
    output logic [BSR_LEN-1:0] pinOut,
    output logic extestActive,
    output logic ispActive,
    output logic [IR_LEN-1:0] ispOpcode,
    output logic ispDataValid,
    input wire logic ispDataReady,
    output logic [7:0] ispData,
    output logic portReleased
);
    // ****************************************
    // pin synchronisers and edge detect
    // ****************************************
    logic [2:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
    logic tckPrev_r, tckPrev_nxt;
    logic tckRise, tckFall, tmsS, tdiS;
    logic stall;

    // a pending rise is held while the byte buffer is full; if tck falls first, the bit is lost
    always_comb begin
        sync1_nxt = {tckPin, tmsPin, tdiPin};
        sync2_nxt = sync1_r;
        tckPrev_nxt = stall ? tckPrev_r : sync2_r[2];
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            tckPrev_r <= 1'b0;
        end else if (clkEn) begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            tckPrev_r <= tckPrev_nxt;
        end
    end
    assign tmsS = sync2_r[1];
    assign tdiS = sync2_r[0];
    // port disabled: no edges seen, machine parked [RULE_12]
    assign tckRise = portEnable && sync2_r[2] && !tckPrev_r;
    assign tckFall = portEnable && !sync2_r[2] && tckPrev_r;
    assign portReleased = !portEnable; // [RULE_12]

    // ****************************************
    // controller state machine
    // ****************************************
    bst_state_t state_r, state_nxt;
    always_comb begin
        state_nxt = state_r;
        if (!portEnable) begin
            state_nxt = ST_RESET;
        end else if (tckRise) begin // [RULE_13]
            case (state_r)
                ST_RESET: state_nxt = tmsS ? ST_RESET : ST_IDLE;
                ST_IDLE:  state_nxt = tmsS ? ST_SELDR : ST_IDLE;
                ST_SELDR: state_nxt = tmsS ? ST_SELIR : ST_CAPDR;
                ST_CAPDR: state_nxt = tmsS ? ST_EX1DR : ST_SHDR;
                ST_SHDR:  state_nxt = tmsS ? ST_EX1DR : ST_SHDR;
                ST_EX1DR: state_nxt = tmsS ? ST_UPDR : ST_PAUDR;
                ST_PAUDR: state_nxt = tmsS ? ST_EX2DR : ST_PAUDR;
                ST_EX2DR: state_nxt = tmsS ? ST_UPDR : ST_SHDR;
                ST_UPDR:  state_nxt = tmsS ? ST_SELDR : ST_IDLE;
                ST_SELIR: state_nxt = tmsS ? ST_RESET : ST_CAPIR;
                ST_CAPIR: state_nxt = tmsS ? ST_EX1IR : ST_SHIR;
                ST_SHIR:  state_nxt = tmsS ? ST_EX1IR : ST_SHIR;
                ST_EX1IR: state_nxt = tmsS ? ST_UPIR : ST_PAUIR;
                ST_PAUIR: state_nxt = tmsS ? ST_EX2IR : ST_PAUIR;
                ST_EX2IR: state_nxt = tmsS ? ST_UPIR : ST_SHIR;
                ST_UPIR:  state_nxt = tmsS ? ST_SELDR : ST_IDLE;
                default:  state_nxt = ST_RESET;
            endcase
        end
    end

    // ****************************************
    // instruction and data registers
    // ****************************************
    logic [IR_LEN-1:0] irShift_r, irShift_nxt, ir_r, ir_nxt;
    logic bypass_r, bypass_nxt;
    logic [ID_LEN-1:0] idShift_r, idShift_nxt;
    logic [BSR_LEN-1:0] bsr_r, bsr_nxt, upd_r, upd_nxt;
    logic [7:0] ispShift_r, ispShift_nxt;
    logic [2:0] ispCnt_r, ispCnt_nxt;
    logic tdo_r, tdo_nxt, oe_r, oe_nxt;
    bst_sel_t sel;
    logic [ID_LEN-1:0] idWord;
    logic bufInValid, bufInReady;

    // id layout, lowest bit forced to one [RULE_06] [RULE_07]
    assign idWord = (ID_LEN'(ID_VER) << ID_VER_POS) | (ID_LEN'(ID_PART) << ID_PART_POS)
                  | (ID_LEN'(ID_MAKER) << ID_MAKER_POS) | ID_LEN'(1);

    // decode; unassigned or missing-variant opcodes fall to bypass [RULE_14]
    always_comb begin
        sel = SEL_BYPASS;
        if (ir_r == OP_EXT) sel = SEL_EXT;
        else if (ir_r == OP_SMP) sel = SEL_BSR;
        else if (ir_r == OP_ID) sel = SEL_ID;
        else if (HAS_USER && ir_r == OP_USR) sel = SEL_USER; // [RULE_08]
        else if (HAS_SIG && ir_r == OP_SIG) sel = SEL_SIG; // [RULE_09]
        else if (ir_r >= OP_ISP_FIRST && ir_r <= OP_ISP_LAST) sel = SEL_ISP; // [RULE_11]
        else if (ir_r == OP_BYP) sel = SEL_BYPASS;
    end

    always_comb begin
        irShift_nxt = irShift_r;
        ir_nxt = ir_r;
        bypass_nxt = bypass_r;
        idShift_nxt = idShift_r;
        bsr_nxt = bsr_r;
        upd_nxt = upd_r;
        ispShift_nxt = ispShift_r;
        ispCnt_nxt = ispCnt_r;
        bufInValid = 1'b0;
        tdo_nxt = tdo_r;
        oe_nxt = oe_r;
        if (state_r == ST_RESET) begin
            ir_nxt = OP_ID;
        end
        if (tckRise) begin
            case (state_r)
                ST_CAPIR: irShift_nxt = IR_CAPTURE;
                ST_SHIR: irShift_nxt = {tdiS, irShift_r[IR_LEN-1:1]}; // [RULE_01]
                ST_UPIR: ir_nxt = irShift_r;
                ST_CAPDR: begin
                    bypass_nxt = 1'b0;
                    ispCnt_nxt = '0;
                    case (sel)
                        SEL_ID: idShift_nxt = idWord; // [RULE_05]
                        SEL_USER: idShift_nxt = userCode; // [RULE_08]
                        SEL_SIG: idShift_nxt = ID_LEN'(signature); // [RULE_09]
                        SEL_BSR, SEL_EXT: bsr_nxt = pinIn; // [RULE_03] [RULE_04]
                        default: idShift_nxt = idShift_r;
                    endcase
                end
                ST_SHDR: begin
                    case (sel)
                        SEL_BYPASS: bypass_nxt = tdiS; // [RULE_02]
                        SEL_BSR, SEL_EXT: bsr_nxt = {tdiS, bsr_r[BSR_LEN-1:1]}; // [RULE_10]
                        SEL_ISP: begin
                            // a stalled buffer drops nothing while tck stays high: shift waits on ready
                            ispShift_nxt = {tdiS, ispShift_r[7:1]};
                            ispCnt_nxt = ispCnt_r + 3'h1;
                            bufInValid = (ispCnt_r == 3'h7);
                        end
                        SEL_SIG: idShift_nxt = {16'h0000, tdiS, idShift_r[SIG_LEN-1:1]};
                        default: idShift_nxt = {tdiS, idShift_r[ID_LEN-1:1]};
                    endcase
                end
                ST_UPDR: begin
                    if (sel == SEL_BSR || sel == SEL_EXT) upd_nxt = bsr_r; // [RULE_03]
                end
                default: ir_nxt = ir_nxt;
            endcase
        end
        // output changes on the falling edge only, except oe clears on any clkEn cycle while the port is disabled [RULE_13]
        if (tckFall) begin
            oe_nxt = (state_r == ST_SHDR) || (state_r == ST_SHIR);
            if (state_r == ST_SHIR) tdo_nxt = irShift_r[0];
            else if (sel == SEL_BYPASS || sel == SEL_ISP) tdo_nxt = bypass_r; // [RULE_02]
            else if (sel == SEL_BSR || sel == SEL_EXT) tdo_nxt = bsr_r[0];
            else tdo_nxt = idShift_r[0];
        end
        if (!portEnable) oe_nxt = 1'b0;
    end

    // isp bytes stall: on a full buffer the edge waits while tck stays high
    assign stall = bufInValid && !bufInReady;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_RESET;
            irShift_r <= IR_CAPTURE;
            ir_r <= OP_ID;
            bypass_r <= 1'b0;
            idShift_r <= '0;
            bsr_r <= '0;
            upd_r <= '0;
            ispShift_r <= '0;
            ispCnt_r <= '0;
            tdo_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (clkEn && !stall) begin
            state_r <= state_nxt;
            irShift_r <= irShift_nxt;
            ir_r <= ir_nxt;
            bypass_r <= bypass_nxt;
            idShift_r <= idShift_nxt;
            bsr_r <= bsr_nxt;
            upd_r <= upd_nxt;
            ispShift_r <= ispShift_nxt;
            ispCnt_r <= ispCnt_nxt;
            tdo_r <= tdo_nxt;
            oe_r <= oe_nxt;
        end
    end

    // ****************************************
    // pins and programming stream
    // ****************************************
    assign extestActive = (sel == SEL_EXT);
    assign pinOut = extestActive ? upd_r : coreOut; // [RULE_04]
    assign tdoOut = tdo_r;
    assign tdoOe = oe_r;
    assign ispActive = (sel == SEL_ISP); // [RULE_11]
    assign ispOpcode = ir_r;

    bst_buf_if #(.W(8)) ispBus ();
    assign ispBus.inValid = bufInValid && clkEn;
    assign ispBus.inData = {tdiS, ispShift_r[7:1]};
    assign bufInReady = ispBus.inReady;
    assign ispBus.outReady = ispDataReady;
    assign ispDataValid = ispBus.outValid;
    assign ispData = ispBus.outData;

    bst_skid_buf #(.W(8), .DEPTH(2)) ispBuf (
        .clock(clock),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .bus(ispBus.buffer)
    );
endmodule : bst_test_port
`default_nettype wire

/* tb/bst_jtag_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// test controller model
// ****************************************
module bst_jtag_ctl (
    input wire logic clock,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one slow tck period: four clocks low, four high; tdo read late in the low half
    task automatic pulse(input logic m, input logic d, output logic q);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clock);
        q = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : pulse
    // five cycles with mode high reach reset from anywhere, then idle
    task automatic reset_tap();
        logic q;
        repeat (5) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask : reset_tap
    // idle to shift, n bits lsb first, then update and back to idle
    task automatic scan(input bit ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        dout = '0;
        pulse(1'b1, ~tdi, q);
        if (ir) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask : scan
endmodule : bst_jtag_ctl
`default_nettype wire

/* tb/bst_test_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module bst_test_port_chk import bst_pkg::*; #(
    parameter int BSR_LEN = BSR_LEN_DEF
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic portEnable,
    input wire logic tckPin,
    input wire logic tdoOut,
    input wire logic tdoOe,
    input wire logic [BSR_LEN-1:0] coreOut,
    input wire logic [BSR_LEN-1:0] pinOut,
    input wire logic extestActive,
    input wire logic ispActive,
    input wire logic [IR_LEN-1:0] ispOpcode,
    input wire logic ispDataValid,
    input wire logic ispDataReady,
    input wire logic [7:0] ispData,
    input wire logic portReleased
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    a_port_released: assert property (portReleased == !portEnable)
        else $error("released flag does not follow enable");
    a_oe_released: assert property ($fell(portEnable) |-> ##[1:3] !tdoOe [*4])
        else $error("data out still enabled after release");
    // tck needs three clocks to reach the core, so a fall shows as three low samples
    a_tdo_on_fall: assert property (portEnable && $changed(tdoOut)
        |-> !tckPin && !$past(tckPin) && !$past(tckPin, 2)) else $error("tdo moved off a fall");
    a_oe_on_fall: assert property (portEnable && $changed(tdoOe)
        |-> !tckPin && !$past(tckPin) && !$past(tckPin, 2)) else $error("oe moved off a fall");
    a_core_pass: assert property (!extestActive |-> pinOut == coreOut)
        else $error("pins disturbed outside external test");
    a_ext_decode: assert property (extestActive == (ispOpcode == OP_EXTEST))
        else $error("external test flag wrong");
    a_isp_decode: assert property (ispActive == (ispOpcode >= OP_ISP_FIRST
        && ispOpcode <= OP_ISP_LAST)) else $error("programming flag wrong");
    a_isp_hold: assert property (disable iff (!arst_n || !portEnable)
        ispDataValid && !ispDataReady |=> ispDataValid && $stable(ispData))
        else $error("stalled byte lost");
    a_reset_state: assert property ($rose(arst_n) |-> ispOpcode == OP_IDCODE
        && !tdoOe && !ispDataValid) else $error("bad state after reset");
endmodule : bst_test_port_chk
bind bst_test_port bst_test_port_chk #(.BSR_LEN(BSR_LEN)) chk (.clock(clock), .arst_n(arst_n),
    .portEnable(portEnable), .tckPin(tckPin), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .coreOut(coreOut), .pinOut(pinOut), .extestActive(extestActive), .ispActive(ispActive),
    .ispOpcode(ispOpcode), .ispDataValid(ispDataValid), .ispDataReady(ispDataReady),
    .ispData(ispData), .portReleased(portReleased));
`default_nettype wire

/* tb/bst_test_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// test port bench
// ****************************************
module bst_test_port_tb_top import bst_pkg::*; ;
    localparam int BL = 96;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic clkEn = 1'b1;
    logic portEnable = 1'b1;
    logic stall = 1'b0;
    logic ispDataReady = 1'b0;
    logic [31:0] userCode = '0;
    logic [15:0] signature = '0;
    logic [BL-1:0] pinIn = '0;
    logic [BL-1:0] coreOut = '0;
    logic [BL-1:0] pinOut;
    logic [9:0] ispOpcode;
    logic [7:0] ispData;
    logic tck, tms, tdi, tdoOut, tdoOe, extestActive, ispActive, ispDataValid, portReleased;
    logic [7:0] got[$];
    int n_mismatch = 0;
    int n_tests = 0;
    // released data line floats up through its pull-up
    wire logic tdoLine = tdoOe ? tdoOut : 1'b1;
    initial forever #50 clock = ~clock;
    bst_test_port #(.BSR_LEN(BL)) uut (.clock(clock), .arst_n(arst_n), .clkEn(clkEn),
        .portEnable(portEnable), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi), .tdoOut(tdoOut),
        .tdoOe(tdoOe), .userCode(userCode), .signature(signature), .pinIn(pinIn),
        .coreOut(coreOut), .pinOut(pinOut), .extestActive(extestActive), .ispActive(ispActive),
        .ispOpcode(ispOpcode), .ispDataValid(ispDataValid), .ispDataReady(ispDataReady),
        .ispData(ispData), .portReleased(portReleased));
    bst_jtag_ctl ctl (.clock(clock), .tdo(tdoLine), .tck(tck), .tms(tms), .tdi(tdi));
    // byte sink: random ready, held off entirely while stall is set
    always @(posedge clock) begin
        ispDataReady <= !stall && ($urandom % 2 == 1);
        if (ispDataValid === 1'b1 && ispDataReady === 1'b1)
            got.push_back(ispData);
    end
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    function automatic logic [31:0] id_word();
        return {ID_VER_DEF, ID_PART_DEF, ID_MAKER_DEF, 1'b1};
    endfunction : id_word
    // every instruction load also checks the captured pattern shifted out
    task automatic ir(input logic [9:0] op);
        logic [127:0] o;
        ctl.scan(1'b1, 10, 128'(op), o);
        check("ir capture", o[9:0], IR_CAPTURE);
    endtask : ir
    // hang guard, several times the expected run
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        $display("FAIL watchdog expected done seen hang");
        complete_run();
    end
    initial begin
        logic [127:0] d;
        logic [127:0] o;
        logic [BL-1:0] pat;
        logic [9:0] op;
        void'($urandom(32'h0140));
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        ctl.reset_tap();
        ctl.scan(1'b0, 32, '0, o);
        check("idcode", o[31:0], id_word());
        $display("test idcode done");
        // bypass itself and unassigned codes all give one stage of delay
        for (int k = 0; k < 5; k++) begin
            op = (k == 0) ? OP_BYPASS : 10'h300 + 10'($urandom % 255);
            ir(op);
            d = 128'($urandom);
            ctl.scan(1'b0, 9, d, o);
            check("bypass", o[8:0], {d[7:0], 1'b0});
        end
        $display("test bypass done");
        userCode <= $urandom;
        signature <= 16'($urandom);
        ir(OP_USERCODE);
        ctl.scan(1'b0, 32, '0, o);
        check("usercode", o[31:0], userCode);
        ir(OP_SIGREAD);
        ctl.scan(1'b0, 16, '0, o);
        check("signature", o[15:0], signature);
        $display("test codes done");
        pinIn <= {$urandom, $urandom, $urandom};
        coreOut <= {$urandom, $urandom, $urandom};
        pat = {$urandom, $urandom, $urandom};
        ir(OP_SAMPLE);
        ctl.scan(1'b0, BL, 128'(pat), o);
        check("sample capture", o[BL-1:0], pinIn);
        check("sample pins", pinOut, coreOut);
        ir(OP_EXTEST);
        check("preload drive", pinOut, pat);
        pinIn <= ~pinIn;
        d = {$urandom, $urandom, $urandom};
        ctl.scan(1'b0, BL, d, o);
        check("extest capture", o[BL-1:0], pinIn);
        check("extest drive", pinOut, d[BL-1:0]);
        $display("test boundary done");
        // two bytes with the sink stalled must both wait in the buffer
        ir(10'h2A5);
        check("isp flags", {ispActive, ispOpcode}, {1'b1, 10'h2A5});
        stall <= 1'b1;
        got.delete();
        d = 128'($urandom);
        ctl.scan(1'b0, 16, d, o);
        check("isp held", ispDataValid, 1'b1);
        stall <= 1'b0;
        repeat (40) @(posedge clock);
        check("isp count", 128'(got.size()), 128'd2);
        check("isp bytes", {got[1], got[0]}, d[15:0]);
        $display("test programming done");
        // frozen core ignores a release until the enable returns
        clkEn <= 1'b0;
        portEnable <= 1'b0;
        repeat (4) @(posedge clock);
        portEnable <= 1'b1;
        repeat (2) @(posedge clock);
        clkEn <= 1'b1;
        repeat (4) @(posedge clock);
        check("frozen ir", ispOpcode, 10'h2A5);
        check("frozen oe", {portReleased, tdoOe}, 2'b00);
        $display("test freeze done");
        portEnable <= 1'b0;
        repeat (4) @(posedge clock);
        check("released", {portReleased, tdoOe}, 2'b10);
        portEnable <= 1'b1;
        repeat (4) @(posedge clock);
        ctl.reset_tap();
        ctl.scan(1'b0, 32, '0, o);
        check("id after release", o[31:0], id_word());
        $display("test release done");
        complete_run();
    end
endmodule : bst_test_port_tb_top
`default_nettype wire
